// ---- hdl/iodr_top.sv ----
`timescale 1ns/1ps
module iodr_top #(
  parameter int INTERVAL_CODE0 = iodr_pkg::IODR_INTERVAL_CODE0,
  parameter int INTERVAL_CODE1 = iodr_pkg::IODR_INTERVAL_CODE1,
  parameter int INTERVAL_CODE2 = iodr_pkg::IODR_INTERVAL_CODE2,
  parameter int INTERVAL_CODE3 = iodr_pkg::IODR_INTERVAL_CODE3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // cpu i/o request, one-cycle strobe
  input wire iodr_pkg::iodr_io_req_t io_req,
  output logic io_internal,
  output logic io_external,
  output logic io_ignore_wait,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // bus state
  input wire logic bus_granted,
  input wire logic wait_state,
  // refresh bus cycle
  output logic refresh_n,
  output logic refresh_busy,
  output logic [7:0] refresh_addr
);
  logic [7:0] dram_refresh_control;
  logic [7:0] io_window_control;
  logic [9:0] interval_cnt;
  logic refresh_pending;
  logic [1:0] ref_cnt;
  logic [1:0] ref_len;
  iodr_pkg::iodr_state_t state;
  iodr_pkg::iodr_state_t next_state;

  // window decode: upper byte zero and bits 7:6 match relocation field
  wire logic [1:0] io_window_relocation = io_window_control[iodr_pkg::IODR_RELOC_MSB:iodr_pkg::IODR_RELOC_LSB];
  wire logic upper_zero = (io_req.addr[15:8] == 8'h00);
  wire logic win_hit = upper_zero && (io_req.addr[7:6] == io_window_relocation);
  wire logic [5:0] reg_ofs = io_req.addr[5:0];
  wire logic hit_refresh_ctrl = win_hit && (reg_ofs == iodr_pkg::IODR_RFR_CTRL_OFS);
  wire logic hit_window_ctrl = win_hit && (reg_ofs == iodr_pkg::IODR_WIN_CTRL_OFS);

  // every access reaches the external bus; internal ones run without waits
  assign io_internal = io_req.valid && win_hit;
  assign io_external = io_req.valid;
  assign io_ignore_wait = (io_req.valid && win_hit) || refresh_busy;

  // register writes; unused refresh control bits always read zero
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      dram_refresh_control <= iodr_pkg::IODR_RFR_CTRL_RST;
      io_window_control <= iodr_pkg::IODR_WIN_CTRL_RST;
    end
    else if (io_req.valid && io_req.wr)
    begin
      if (hit_refresh_ctrl)
        dram_refresh_control <= io_req.wdata & iodr_pkg::IODR_RFR_CTRL_MASK;
      if (hit_window_ctrl)
        io_window_control <= io_req.wdata;
    end
  end

  // read data from registers; external bus data never used here
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end
    else
    begin
      io_rvalid <= io_req.valid && !io_req.wr && win_hit;
      io_rdata <= hit_refresh_ctrl ? dram_refresh_control : (hit_window_ctrl ? io_window_control : 8'h00);
    end
  end

  // interval selection per cycle code
  wire logic [1:0] cyc_sel = {dram_refresh_control[iodr_pkg::IODR_CYC_HI_BIT],
                              dram_refresh_control[iodr_pkg::IODR_CYC_LO_BIT]};
  wire logic [9:0] interval_max = (cyc_sel == 2'h0) ? 10'(INTERVAL_CODE0 - 1) :
                                  (cyc_sel == 2'h1) ? 10'(INTERVAL_CODE1 - 1) :
                                  (cyc_sel == 2'h2) ? 10'(INTERVAL_CODE2 - 1) :
                                  10'(INTERVAL_CODE3 - 1);
  wire logic refresh_en = dram_refresh_control[iodr_pkg::IODR_REF_EN_BIT];
  wire logic tick = (interval_cnt >= interval_max);

  // timer runs even while bus is granted, so no relation to bus exchange
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      interval_cnt <= 10'h000;
    else
      interval_cnt <= tick ? 10'h000 : interval_cnt + 10'h001;
  end

  // a request waits for a free bus; it is dropped if refresh is disabled
  wire logic can_start = refresh_pending && !bus_granted && !wait_state && !io_req.valid;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      refresh_pending <= 1'b0;
    else if (!refresh_en)
      refresh_pending <= 1'b0;
    else if (tick)
      refresh_pending <= 1'b1;
    else if (state == iodr_pkg::IODR_IDLE && can_start)
      refresh_pending <= 1'b0;
  end

  // refresh cycle: length latched at start so a mid-cycle write can't stretch it
  always_comb
  begin
    case (state)
      iodr_pkg::IODR_IDLE: next_state = can_start ? iodr_pkg::IODR_REFRESH : iodr_pkg::IODR_IDLE;
      iodr_pkg::IODR_REFRESH: next_state = (ref_cnt == ref_len - 2'h1) ? iodr_pkg::IODR_IDLE : iodr_pkg::IODR_REFRESH;
      default: next_state = iodr_pkg::IODR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= iodr_pkg::IODR_IDLE;
      ref_cnt <= 2'h0;
      ref_len <= iodr_pkg::IODR_REF_LONG_LEN;
      refresh_addr <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (state == iodr_pkg::IODR_IDLE && can_start)
      begin
        ref_cnt <= 2'h0;
        ref_len <= dram_refresh_control[iodr_pkg::IODR_REF_WAIT_BIT] ?
                   iodr_pkg::IODR_REF_LONG_LEN : iodr_pkg::IODR_REF_SHORT_LEN;
      end
      else if (state == iodr_pkg::IODR_REFRESH)
        ref_cnt <= ref_cnt + 2'h1;
      if (state == iodr_pkg::IODR_REFRESH && next_state == iodr_pkg::IODR_IDLE)
        refresh_addr <= refresh_addr + 8'h01;
    end
  end

  // strobe low for the whole refresh; row drives A0-A7 meanwhile
  assign refresh_busy = (state == iodr_pkg::IODR_REFRESH);
  assign refresh_n = !refresh_busy;
endmodule

// ---- hdl/iodr_pkg.sv ----
package iodr_pkg;
  localparam logic [5:0] IODR_RFR_CTRL_OFS = 6'h36;
  localparam logic [5:0] IODR_WIN_CTRL_OFS = 6'h3f;
  localparam int IODR_RELOC_MSB = 7;
  localparam int IODR_RELOC_LSB = 6;
  localparam int IODR_REF_EN_BIT = 7;
  localparam int IODR_REF_WAIT_BIT = 6;
  localparam int IODR_CYC_HI_BIT = 1;
  localparam int IODR_CYC_LO_BIT = 0;
  localparam logic [7:0] IODR_RFR_CTRL_RST = 8'hc0;
  localparam logic [7:0] IODR_WIN_CTRL_RST = 8'h00;
  localparam logic [7:0] IODR_RFR_CTRL_MASK = 8'hc3;
  localparam int IODR_INTERVAL_CODE0 = 248;
  localparam int IODR_INTERVAL_CODE1 = 496;
  localparam int IODR_INTERVAL_CODE2 = 744;
  localparam int IODR_INTERVAL_CODE3 = 992;
  localparam logic [1:0] IODR_REF_SHORT_LEN = 2'h2;
  localparam logic [1:0] IODR_REF_LONG_LEN = 2'h3;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } iodr_io_req_t;

  typedef enum logic [0:0] {
    IODR_IDLE = 1'b0,
    IODR_REFRESH = 1'b1
  } iodr_state_t;
endpackage

// ---- sim/iodr_checker.sv ----
`timescale 1ns/1ps
module iodr_checker (
  // watched ports
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire iodr_pkg::iodr_io_req_t io_req,
  input wire logic io_internal,
  input wire logic io_external,
  input wire logic io_ignore_wait,
  input wire logic io_rvalid,
  input wire logic bus_granted,
  input wire logic wait_state,
  input wire logic refresh_n,
  input wire logic refresh_busy,
  input wire logic [7:0] refresh_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // strobe steps: two low clocks, then release after one more or none
  sequence s_low2; (!refresh_n)[*2]; endsequence
  sequence s_rel; refresh_n; endsequence
  property p_len; $fell(refresh_n) |-> s_low2 ##[1:2] s_rel; endproperty
  property p_ext; io_req.valid |-> io_external; endproperty
  property p_up; io_req.valid && io_req.addr[15:8] != 8'h00 |-> !io_internal; endproperty
  property p_rd; io_req.valid && io_internal && !io_req.wr |=> io_rvalid; endproperty
  property p_wt; !refresh_n |-> io_ignore_wait; endproperty
  property p_bsy; refresh_busy == !refresh_n; endproperty
  property p_go; $fell(refresh_n) |-> !$past(bus_granted) && !$past(wait_state); endproperty
  property p_row; $rose(refresh_n) |-> refresh_addr == $past(refresh_addr) + 8'h01; endproperty
  a_len: assert property (p_len) else $error("refresh length wrong");
  a_ext: assert property (p_ext) else $error("access not mirrored");
  a_up: assert property (p_up) else $error("upper byte decoded");
  a_rd: assert property (p_rd) else $error("no read answer");
  a_wt: assert property (p_wt) else $error("wait honoured");
  a_bsy: assert property (p_bsy) else $error("busy and strobe differ");
  a_go: assert property (p_go) else $error("refresh while blocked");
  a_row: assert property (p_row) else $error("row not advanced");
endmodule
bind iodr_top iodr_checker iodr_checker_i (.sys_clk, .sys_rst, .io_req, .io_internal, .io_external,
  .io_ignore_wait, .io_rvalid, .bus_granted, .wait_state, .refresh_n, .refresh_busy, .refresh_addr);

// ---- sim/iodr_dram_model.sv ----
`timescale 1ns/1ps
module iodr_dram_model (
  // strobe seen at the memory
  input wire logic sys_clk,
  input wire logic refresh_n,
  // measured results
  output int last_len = 0,
  output int n_ref = 0
);
  int cnt = 0;
  // a row counts as refreshed when the strobe is released, so a cut strobe still shows
  always @(posedge sys_clk)
  begin
    cnt <= refresh_n ? 0 : cnt + 1;
    if (refresh_n && cnt > 0)
    begin
      last_len <= cnt;
      n_ref <= n_ref + 1;
    end
  end
endmodule

// ---- sim/iodr_top_tb_top.sv ----
`timescale 1ns/1ps
module iodr_top_tb_top;
  logic sys_clk = 0, sys_rst = 1, bus_granted = 0, wait_state = 0, prev_n = 1, hit, rv;
  logic io_internal, io_external, io_ignore_wait, io_rvalid, refresh_n, refresh_busy;
  logic [7:0] io_rdata, refresh_addr, rd;
  iodr_pkg::iodr_io_req_t io_req = '0;
  int error_cnt = 0, checks = 0, cyc = 0, t_fall = 0, gap = 0, last_len, n_ref, s;
  iodr_top iodr_top_i (.sys_clk, .sys_rst, .io_req, .io_internal, .io_external, .io_ignore_wait,
    .io_rdata, .io_rvalid, .bus_granted, .wait_state, .refresh_n, .refresh_busy, .refresh_addr);
  iodr_dram_model iodr_dram_model_i (.sys_clk, .refresh_n, .last_len, .n_ref);
  initial forever #10 sys_clk = ~sys_clk;
  // fall-to-fall spacing, and a ceiling well above the whole run
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    prev_n <= refresh_n;
    if (prev_n === 1'b1 && refresh_n === 1'b0)
    begin
      gap <= cyc - t_fall;
      t_fall <= cyc;
    end
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one-cycle request; flags sampled while it is up, answer one edge later
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1 io_req = '{1'b1, w, a, d};
    #1 hit = io_internal;
    chk(io_external, 1'b1);
    @(posedge sys_clk) #1 io_req.valid = 1'b0;
    rv = io_rvalid;
    rd = io_rdata;
  endtask
  task nref(input int k);
    s = n_ref + k;
    repeat (2000) if (n_ref < s) @(posedge sys_clk);
  endtask
  task t_regs;
    acc(0, 16'h0036, 8'h00);
    chk({hit, rv, rd}, {2'b11, 8'hc0});
    acc(0, 16'h003f, 8'h00);
    chk({hit, rd}, {1'b1, 8'h00});
    acc(0, 16'h0136, 8'h00);
    chk({hit, rv}, 2'b00);
  endtask
  task t_window;
    acc(1, 16'h003f, 8'h40);
    acc(0, 16'h0076, 8'h00);
    chk({hit, rd}, {1'b1, 8'hc0});
    acc(0, 16'h0036, 8'h00);
    chk(hit, 1'b0);
    acc(1, 16'h007f, 8'h00);
  endtask
  task t_interval;
    nref(2);
    chk(gap, 248);
    chk(last_len, 3);
  endtask
  task t_short;
    acc(1, 16'h0036, 8'hbc);
    acc(0, 16'h0036, 8'h00);
    chk(rd, 8'h80);
    nref(2);
    chk(last_len, 2);
  endtask
  // blocking does not stop the timer, so both holds span a tick
  task t_block;
    s = n_ref;
    #1 bus_granted = 1'b1;
    repeat (300) @(posedge sys_clk);
    #1 bus_granted = 1'b0;
    wait_state = 1'b1;
    repeat (300) @(posedge sys_clk);
    #1 wait_state = 1'b0;
    chk(n_ref, s);
  endtask
  task t_disable;
    acc(1, 16'h0036, 8'h00);
    // the refresh released by t_block may still be finishing; count only after it
    repeat (8) @(posedge sys_clk);
    s = n_ref;
    repeat (600) @(posedge sys_clk);
    chk(n_ref, s);
    chk(refresh_addr, 8'(n_ref));
  endtask
  initial
  begin
    repeat (4) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    t_regs;
    t_window;
    t_interval;
    t_short;
    t_block;
    t_disable;
    print_verdict;
  end
endmodule
